// ### hdl/ecs_consts.svh
// Constants for the expansion chip-select decoder: register offsets,
// field positions, reset values and default timing counts.
// Assumes inclusion by bare name from the decoder sources.
`ifndef ECS_CONSTS_SVH
`define ECS_CONSTS_SVH

`define ECS_OFF_STATUS   16'h1058
`define ECS_OFF_STRETCH  16'h105C
`define ECS_OFF_CTL      16'h105D
`define ECS_OFF_GBASE    16'h105E
`define ECS_OFF_GSIZE    16'h105F

`define ECS_RST_STRETCH  8'h00
`define ECS_RST_CTL      8'h00
`define ECS_RST_GBASE    8'h00
`define ECS_RST_GSIZE    8'h07

// Select control fields
`define ECS_B_IO1_EN     7
`define ECS_B_IO1_POL    6
`define ECS_B_IO2_EN     5
`define ECS_B_IO2_POL    4
`define ECS_B_PRIO       3
`define ECS_B_PCS_EN     2
// Size control fields
`define ECS_B_IO1_TIM    7
`define ECS_B_IO2_TIM    6
`define ECS_B_GEN_POL    4
`define ECS_B_GEN_TIM    3
`define ECS_GSIZE_OFF    3'h7

// I/O select window inside the register page
`define ECS_IO1_LOW      12'h060

// E clock half period in core cycles
`define ECS_E_HALF_CYC   4

`endif

// ### hdl/ecs_pkg.sv
// Types shared by the expansion chip-select decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package ecs_pkg;
  typedef enum logic [2:0] {
    ECS_ST_IDLE = 3'b001,
    ECS_ST_LOW  = 3'b010,
    ECS_ST_HIGH = 3'b100
  } ecs_state_e;

  typedef logic [15:0] ecs_addr_t;
  typedef logic [1:0]  ecs_stretch_t;
  typedef logic [7:0]  ecs_byte_t;
endpackage : ecs_pkg

// ### hdl/ecs_sel_out.sv
// One select pin stage: enable, timing choice and polarity, registered.
// Assumes address and E phase inputs come from the same clock domain.
`timescale 1ns/100ps
`default_nettype none

module ecs_sel_out
(
  input  wire logic i_core_clk,
  input  wire logic i_rstn,
  input  wire logic i_en,
  input  wire logic i_hit,
  input  wire logic i_active_high,
  input  wire logic i_addr_valid,
  input  wire logic i_addr_phase,
  input  wire logic i_e_phase,
  output logic      o_pin,
  output logic      o_oe
);
  logic active;

  assign active = i_en & i_hit & (i_addr_valid ? i_addr_phase : i_e_phase);

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      o_pin <= 1'b0;
      o_oe  <= 1'b0;
    end
    else
    begin
      // Pin left to port logic while disabled
      o_oe  <= i_en;
      o_pin <= i_en ? (i_active_high ? active : ~active) : 1'b0;
    end
  end

  // Enabled pin follows polarity: inactive level outside the bus cycle
  sel_idle_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_en && !i_addr_phase) |=> (o_pin != $past(i_active_high)))
    else $error("select not idle outside cycle");
endmodule : ecs_sel_out

`default_nettype wire

// ### hdl/ecs_decoder.sv
// Expansion bus chip-select decoder: registers, bus cycle and E timing,
// address decode and four port G select pins.
// Assumes register port and bus requests come from core-clock logic;
// the mode strap arrives from a pin.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "ecs_consts.svh"

module ecs_decoder
#(
  parameter int E_HALF_CYCLES = `ECS_E_HALF_CYC
)
(
  input  wire logic              i_core_clk,
  input  wire logic              i_rstn,
  input  wire logic              i_expanded_mode,
  input  wire logic [3:0]        i_reg_base,
  input  wire ecs_pkg::ecs_addr_t i_reg_addr,
  input  wire ecs_pkg::ecs_byte_t i_reg_wdata,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  output ecs_pkg::ecs_byte_t     o_reg_rdata,
  input  wire logic              i_bus_req,
  input  wire ecs_pkg::ecs_addr_t i_bus_addr,
  output logic                   o_bus_busy,
  output logic                   o_bus_done,
  output logic                   o_e_clk,
  output logic [3:0]             o_pg_sel,
  output logic [3:0]             o_pg_sel_oe
);
  import ecs_pkg::*;

  localparam int CW = $clog2(7 * E_HALF_CYCLES + 1);
  // Select indices: io one, io two, general, program
  localparam int S_IO1 = 0;
  localparam int S_IO2 = 1;
  localparam int S_GEN = 2;
  localparam int S_PRG = 3;

  ecs_byte_t    stretch_ctl;
  ecs_byte_t    enable_ctl;
  ecs_byte_t    gen_base;
  ecs_byte_t    gen_size;
  logic         mode_s1;
  logic         mode_s2;
  logic         mode_s3;
  logic         exp_mode;
  logic         strap_pending;
  ecs_state_e   st;
  logic [CW-1:0] cnt;
  logic [3:0]   win_q;
  ecs_stretch_t stretch_q;
  logic [3:0]   hit_now;
  logic [3:0]   win_now;
  logic [3:0]   ens;
  logic [3:0]   pol_high;
  logic [3:0]   tim_av;
  ecs_stretch_t str_of [4];
  ecs_stretch_t next_stretch;
  logic         take;

  function automatic logic gen_hit(input ecs_addr_t a,
                                   input logic [5:0] base,
                                   input logic [2:0] size);
    logic [5:0] m;
    m = 6'h3F << (3'h6 - size);
    gen_hit = (size != `ECS_GSIZE_OFF) && (((a[15:10] ^ base) & m) == 6'h00);
  endfunction : gen_hit

  function automatic logic prog_hit(input ecs_addr_t a,
                                    input logic [1:0] psz);
    logic [2:0] m;
    m = 3'h7 << (2'h3 - psz);
    prog_hit = (a[15:13] & m) == m;
  endfunction : prog_hit

  function automatic logic [CW-1:0] hi_len(input ecs_stretch_t s);
    int n;
    n = E_HALF_CYCLES * (1 + 2 * int'(s));
    hi_len = CW'(n);
  endfunction : hi_len

  // Mode strap: three stages, a change counts once stages two and three agree
  always_ff @(posedge i_core_clk)
  begin
    mode_s1 <= i_expanded_mode;
    mode_s2 <= mode_s1;
    mode_s3 <= mode_s2;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      exp_mode <= 1'b0;
    else if (mode_s2 == mode_s3)
      exp_mode <= mode_s3;
  end

  // Program enable is caught from the strap after reset release
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      strap_pending <= 1'b1;
    else if (mode_s2 == mode_s3)
      strap_pending <= 1'b0;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      stretch_ctl <= `ECS_RST_STRETCH;
    else if (i_reg_wr && i_reg_addr == `ECS_OFF_STRETCH)
      stretch_ctl <= i_reg_wdata;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      enable_ctl <= `ECS_RST_CTL;
    else if (strap_pending && mode_s2 == mode_s3)
      enable_ctl[`ECS_B_PCS_EN] <= mode_s3;
    else if (i_reg_wr && i_reg_addr == `ECS_OFF_CTL)
      enable_ctl <= i_reg_wdata;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      gen_base <= `ECS_RST_GBASE;
    else if (i_reg_wr && i_reg_addr == `ECS_OFF_GBASE)
      gen_base <= {i_reg_wdata[7:2], 2'h0};
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      gen_size <= `ECS_RST_GSIZE;
    else if (i_reg_wr && i_reg_addr == `ECS_OFF_GSIZE)
      gen_size <= {i_reg_wdata[7:6], 1'b0, i_reg_wdata[4:0]};
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      o_reg_rdata <= 8'h00;
    else if (i_reg_rd)
    begin
      case (i_reg_addr)
        `ECS_OFF_STRETCH: o_reg_rdata <= stretch_ctl;
        `ECS_OFF_CTL:     o_reg_rdata <= enable_ctl;
        `ECS_OFF_GBASE:   o_reg_rdata <= gen_base;
        `ECS_OFF_GSIZE:   o_reg_rdata <= gen_size;
        `ECS_OFF_STATUS:  o_reg_rdata <= {stretch_q, win_q, o_bus_busy,
                                          exp_mode};
        default:          o_reg_rdata <= 8'h00;
      endcase
    end
    else
      o_reg_rdata <= 8'h00;
  end

  // Enables, gated by the expanded mode
  assign ens[S_IO1] = exp_mode & enable_ctl[`ECS_B_IO1_EN];
  assign ens[S_IO2] = exp_mode & enable_ctl[`ECS_B_IO2_EN];
  assign ens[S_GEN] = exp_mode & (gen_size[2:0] != `ECS_GSIZE_OFF);
  assign ens[S_PRG] = exp_mode & enable_ctl[`ECS_B_PCS_EN];

  assign pol_high[S_IO1] = enable_ctl[`ECS_B_IO1_POL];
  assign pol_high[S_IO2] = enable_ctl[`ECS_B_IO2_POL];
  assign pol_high[S_GEN] = gen_size[`ECS_B_GEN_POL];
  assign pol_high[S_PRG] = 1'b0;

  assign tim_av[S_IO1] = gen_size[`ECS_B_IO1_TIM];
  assign tim_av[S_IO2] = gen_size[`ECS_B_IO2_TIM];
  assign tim_av[S_GEN] = gen_size[`ECS_B_GEN_TIM];
  assign tim_av[S_PRG] = 1'b1;

  // Stretch field A is the upper bit of each pair
  assign str_of[S_IO1] = stretch_ctl[7:6];
  assign str_of[S_IO2] = stretch_ctl[5:4];
  assign str_of[S_GEN] = stretch_ctl[3:2];
  assign str_of[S_PRG] = stretch_ctl[1:0];

  // Address decode of the current request
  assign hit_now[S_IO1] = (i_bus_addr[15:12] == i_reg_base)
                        && !i_bus_addr[11]
                        && (i_bus_addr[11:0] >= `ECS_IO1_LOW);
  assign hit_now[S_IO2] = (i_bus_addr[15:12] == i_reg_base)
                        && i_bus_addr[11];
  assign hit_now[S_GEN] = gen_hit(i_bus_addr, gen_base[7:2],
                                  gen_size[2:0]);
  assign hit_now[S_PRG] = prog_hit(i_bus_addr, enable_ctl[1:0]);

  // Overlap of general and program selects: the losing one is held inactive
  always_comb
  begin
    win_now = hit_now & ens;
    if (win_now[S_GEN] && win_now[S_PRG])
    begin
      if (enable_ctl[`ECS_B_PRIO])
        win_now[S_PRG] = 1'b0;
      else
        win_now[S_GEN] = 1'b0;
    end
  end

  // Longest stretch among the winners sets the cycle length
  always_comb
  begin
    next_stretch = 2'h0;
    for (int i = 0; i < 4; i++)
    begin
      if (win_now[i] && str_of[i] > next_stretch)
        next_stretch = str_of[i];
    end
  end

  assign take = i_bus_req && (st == ECS_ST_IDLE);

  // Bus cycle: E low half, then E high half plus stretch
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      st  <= ECS_ST_IDLE;
      cnt <= '0;
    end
    else
    begin
      case (st)
        ECS_ST_IDLE:
          if (take)
          begin
            st  <= ECS_ST_LOW;
            cnt <= CW'(E_HALF_CYCLES - 1);
          end
        ECS_ST_LOW:
          if (cnt == '0)
          begin
            st  <= ECS_ST_HIGH;
            cnt <= hi_len(stretch_q) - CW'(1);
          end
          else
            cnt <= cnt - CW'(1);
        ECS_ST_HIGH:
          if (cnt == '0)
            st <= ECS_ST_IDLE;
          else
            cnt <= cnt - CW'(1);
        default:
        begin
          st  <= ECS_ST_IDLE;
          cnt <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      win_q     <= 4'h0;
      stretch_q <= 2'h0;
    end
    else if (take)
    begin
      win_q     <= win_now;
      stretch_q <= next_stretch;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      o_e_clk    <= 1'b0;
      o_bus_busy <= 1'b0;
      o_bus_done <= 1'b0;
    end
    else
    begin
      o_e_clk    <= (st == ECS_ST_HIGH);
      o_bus_busy <= (st != ECS_ST_IDLE);
      o_bus_done <= (st == ECS_ST_HIGH) && (cnt == '0);
    end
  end

  // Pin stages share the E and address phases, so E-timed selects track E exactly
  generate
    for (genvar g = 0; g < 4; g++)
    begin : g_sel
      ecs_sel_out u_sel (
        .i_core_clk    (i_core_clk),
        .i_rstn        (i_rstn),
        .i_en          (ens[g]),
        .i_hit         (win_q[g]),
        .i_active_high (pol_high[g]),
        .i_addr_valid  (tim_av[g]),
        .i_addr_phase  (st != ECS_ST_IDLE),
        .i_e_phase     (st == ECS_ST_HIGH),
        .o_pin         (o_pg_sel[g]),
        .o_oe          (o_pg_sel_oe[g])
      );
    end
  endgenerate

  // Checking helpers
  logic [CW-1:0] e_hi_run;
  logic [CW-1:0] e_hi_expect;

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      e_hi_run <= '0;
    else if (o_e_clk)
      e_hi_run <= e_hi_run + CW'(1);
    else
      e_hi_run <= '0;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      e_hi_expect <= '0;
    else if (st == ECS_ST_LOW && cnt == '0)
      e_hi_expect <= hi_len(stretch_q);
  end

  single_chip_off_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rstn) !exp_mode |=> (o_pg_sel_oe == 4'h0))
    else $error("select driven in single-chip mode");

  io_one_pin_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rstn)
    (exp_mode && enable_ctl[`ECS_B_IO1_EN]) |=> o_pg_sel_oe[S_IO1])
    else $error("io one select not on its pin");

  io_two_pin_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rstn)
    (exp_mode && !enable_ctl[`ECS_B_IO2_EN]) |=> !o_pg_sel_oe[S_IO2])
    else $error("io two pin not released");

  prog_pin_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rstn)
    (exp_mode && enable_ctl[`ECS_B_PCS_EN]) |=> o_pg_sel_oe[S_PRG])
    else $error("program enable not honoured");

  io_one_assert_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rstn)
    (take && win_now[S_IO1] && tim_av[S_IO1] && $stable(enable_ctl))
    ##1 $stable(enable_ctl) |=> (o_pg_sel[S_IO1] == pol_high[S_IO1]))
    else $error("io one select not asserted");

  prog_active_low_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rstn)
    (ens[S_PRG] && win_q[S_PRG] && st != ECS_ST_IDLE) |=> !o_pg_sel[S_PRG])
    else $error("program select not low in cycle");

  overlap_one_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rstn) !(win_now[S_GEN] && win_now[S_PRG]))
    else $error("both overlapping selects won");

  gen_size_off_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rstn)
    (gen_size[2:0] == `ECS_GSIZE_OFF) |-> !win_now[S_GEN])
    else $error("general select hit while disabled");

  e_stretch_len_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rstn) $fell(o_e_clk) |-> (e_hi_run == e_hi_expect))
    else $error("E high length does not match stretch");

  e_low_half_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rstn)
    take |=> (!o_e_clk && o_bus_busy == 1'b0) ##1 o_bus_busy)
    else $error("bus cycle did not start after request");
endmodule : ecs_decoder

`default_nettype wire

// ### verif/ecs_ext_dev.sv
// Model of an external device on the expansion bus: measures each E-high
// run and keeps the select pin levels seen during it.
// Assumes it shares the core clock and pin levels of the decoder.
`timescale 1ns/100ps
`default_nettype none

module ecs_ext_dev
(
  input  wire logic       i_core_clk,
  input  wire logic       i_e_clk,
  input  wire logic [3:0] i_sel,
  output int              o_e_len,
  output logic [3:0]      o_sel_e
);
  int run = 0;

  initial o_e_len = 0;

  // Length of E high, stretch included, as the device sees it
  always @(posedge i_core_clk)
  begin
    if (i_e_clk === 1'b1)
    begin
      run <= run + 1;
      o_sel_e <= i_sel;
    end
    else if (run != 0)
    begin
      o_e_len <= run;
      run <= 0;
    end
  end
endmodule : ecs_ext_dev

`default_nettype wire

// ### verif/expansion_chip_select_decoder_tb.sv
// Self-checking bench for the expansion chip-select decoder.
// Assumes E half period of 2 core cycles and register page nibble 1.
`timescale 1ns/100ps
`default_nettype none
`include "ecs_consts.svh"

module expansion_chip_select_decoder_tb;
  import ecs_pkg::*;

  logic       clk = 0;
  logic       rstn = 0;
  logic       mode = 1;
  ecs_addr_t  raddr = 0;
  ecs_byte_t  wdata = 0;
  logic       wr = 0;
  logic       rd = 0;
  ecs_byte_t  rdata;
  logic       req = 0;
  ecs_addr_t  baddr = 0;
  logic       busy;
  logic       done;
  logic       e_clk;
  logic [3:0] sel;
  logic [3:0] oe;
  int         n_fail = 0;
  int         check_count = 0;
  int         cycles = 0;

  ecs_decoder #(.E_HALF_CYCLES(2)) ecs_decoder_i (
    .i_core_clk(clk), .i_rstn(rstn), .i_expanded_mode(mode),
    .i_reg_base(4'h1), .i_reg_addr(raddr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .i_bus_req(req), .i_bus_addr(baddr), .o_bus_busy(busy),
    .o_bus_done(done), .o_e_clk(e_clk), .o_pg_sel(sel),
    .o_pg_sel_oe(oe));

  ecs_ext_dev ecs_ext_dev_i (.i_core_clk(clk), .i_e_clk(e_clk),
    .i_sel(sel), .o_e_len(), .o_sel_e());

  initial forever #4 clk = ~clk;

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      n_fail++;
      test_done();
    end
  end

  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk

  task automatic rst(input logic md);
    @(posedge clk);
    mode <= md;
    rstn <= 0;
    repeat (5) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
  endtask : rst

  task automatic wreg(input ecs_addr_t a, input ecs_byte_t d);
    @(posedge clk);
    raddr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask : wreg

  task automatic rreg(input ecs_addr_t a, input ecs_byte_t x);
    @(posedge clk);
    raddr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 chk(rdata === x, "register read");
  endtask : rreg

  // Pin levels under mask: hi during E high, lo in the address phase
  task automatic bus(input ecs_addr_t a, input logic [3:0] mk,
                     input logic [3:0] hi, lo, input int hl);
    logic [3:0] seen;
    int n;
    seen = 4'hX;
    @(posedge clk);
    req <= 1;
    baddr <= a;
    @(posedge clk);
    req <= 0;
    for (n = 0; n < 60; n++)
    begin
      @(posedge clk);
      #1 if (busy === 1'b1 && e_clk === 1'b0 && n < 3) seen = sel;
      if (done === 1'b1) break;
    end
    chk(done === 1'b1, "bus cycle never ended");
    repeat (2) @(posedge clk);
    #1 chk((ecs_ext_dev_i.o_sel_e & mk) === hi, "select level in E high");
    chk((seen & mk) === lo, "select level in address phase");
    chk(ecs_ext_dev_i.o_e_len == hl, "E high length");
  endtask : bus

  task automatic t_reset;
    rreg(`ECS_OFF_STRETCH, 8'h00);
    rreg(`ECS_OFF_CTL, 8'h04);
    rreg(`ECS_OFF_GBASE, 8'h00);
    rreg(`ECS_OFF_GSIZE, 8'h07);
    rreg(16'h1060, 8'h00);
    rreg(`ECS_OFF_STATUS, 8'h01);
    chk(oe === 4'h8, "only program select owns its pin");
    wreg(`ECS_OFF_GBASE, 8'hFF);
    rreg(`ECS_OFF_GBASE, 8'hFC);
    $display("reset test done");
  endtask : t_reset

  task automatic t_io;
    int s;
    wreg(`ECS_OFF_CTL, 8'hC4);
    // Pin enable follows the register one edge later
    @(posedge clk);
    #1 chk(oe === 4'h9, "io one pin enable");
    bus(16'h1060, 4'h1, 4'h1, 4'h0, 2);
    bus(16'h17FF, 4'h1, 4'h1, 4'h0, 2);
    bus(16'h105F, 4'h1, 4'h0, 4'h0, 2);
    wreg(`ECS_OFF_GSIZE, 8'h87);
    bus(16'h1060, 4'h1, 4'h1, 4'h1, 2);
    wreg(`ECS_OFF_CTL, 8'h24);
    @(posedge clk);
    #1 chk(oe === 4'hA, "io two pin enable");
    for (s = 0; s < 4; s++)
    begin
      wreg(`ECS_OFF_STRETCH, 8'(s << 4));
      bus(16'h1800, 4'h2, 4'h0, 4'h2, 2 * (1 + 2 * s));
    end
    bus(16'h1FFF, 4'h2, 4'h0, 4'h2, 14);
    bus(16'h17FF, 4'h2, 4'h2, 4'h2, 2);
    $display("io select test done");
  endtask : t_io

  task automatic t_prog;
    ecs_addr_t st[4];
    int k;
    st = '{16'h0000, 16'h8000, 16'hC000, 16'hE000};
    wreg(`ECS_OFF_STRETCH, 8'h00);
    for (k = 0; k < 4; k++)
    begin
      wreg(`ECS_OFF_CTL, 8'(4 + k));
      bus(st[k], 4'h8, 4'h0, 4'h0, 2);
      if (k > 0)
        bus(st[k] - 16'h1, 4'h8, 4'h8, 4'h8, 2);
    end
    $display("program select test done");
  endtask : t_prog

  task automatic t_gen;
    wreg(`ECS_OFF_CTL, 8'h00);
    wreg(`ECS_OFF_GBASE, 8'h40);
    wreg(`ECS_OFF_GSIZE, 8'h1E);
    bus(16'h43FF, 4'h4, 4'h4, 4'h4, 2);
    bus(16'h4400, 4'h4, 4'h0, 4'h0, 2);
    wreg(`ECS_OFF_GSIZE, 8'h1D);
    bus(16'h4400, 4'h4, 4'h4, 4'h4, 2);
    wreg(`ECS_OFF_GSIZE, 8'h1F);
    bus(16'h4000, 4'h4, 4'h0, 4'h0, 2);
    wreg(`ECS_OFF_GSIZE, 8'h06);
    bus(16'h4000, 4'h4, 4'h0, 4'h4, 2);
    wreg(`ECS_OFF_GSIZE, 8'h18);
    bus(16'h0123, 4'h4, 4'h4, 4'h4, 2);
    $display("general select test done");
  endtask : t_gen

  task automatic t_prio;
    wreg(`ECS_OFF_GBASE, 8'h00);
    // Different stretches so the winner shows in the E length
    wreg(`ECS_OFF_STRETCH, 8'h09);
    wreg(`ECS_OFF_CTL, 8'h04);
    bus(16'h2000, 4'hC, 4'h0, 4'h0, 6);
    wreg(`ECS_OFF_CTL, 8'h0C);
    bus(16'h2000, 4'hC, 4'hC, 4'hC, 10);
    $display("priority test done");
  endtask : t_prio

  task automatic t_single;
    rst(1'b0);
    rreg(`ECS_OFF_CTL, 8'h00);
    wreg(`ECS_OFF_CTL, 8'hE4);
    repeat (2) @(posedge clk);
    #1 chk(oe === 4'h0, "no select pin in single-chip mode");
    $display("single-chip test done");
  endtask : t_single

  task automatic test_done;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  initial
  begin
    rst(1'b1);
    t_reset();
    t_io();
    t_prog();
    t_gen();
    t_prio();
    t_single();
    test_done();
  end
endmodule : expansion_chip_select_decoder_tb

`default_nettype wire
